// ---- logic/fps_defines.vh ----
// constants for the flyback protection sequencer
//
// Summary of operation
// RULE_01: on reaching the start-up threshold the mains-detect and temperature input is checked before switching.
// RULE_02: switching starts only when the brownin current level is exceeded and the temperature level is above its detect threshold.
// RULE_03: after switching begins the peak current limit ramps up over a 3.5 ms soft-start.
// RULE_04: any protection stops the gate drive, then leads to restart or latched off.
// RULE_05: brownout and maximum duty protection cause a restart.
// RULE_06: overpower, undervoltage lockout, overvoltage and overtemperature protections latch off.
// RULE_07: a restart waits for the lockout threshold, powers down, recharges to start-up and resumes.
// RULE_08: a latched protection enters power-down at once and asserts the supply clamp.
// RULE_09: supply below the lockout threshold while switching latches off instead of restarting.
// RULE_10: the on-time of each period is cut so the duty cycle stays at or below 90 percent.
// RULE_11: at low power the peak limit is held at 22 percent and the frequency is reduced.
// RULE_12: eight consecutive strokes at maximum duty fire the maximum duty protection.
// RULE_13: brownout is declared after 32 ms continuously below the brownout level.
// RULE_14: overpower fires when the overpower condition persists beyond 160 ms.
// RULE_15: supply overvoltage fires after four consecutive cycles above threshold, count clears otherwise.
// RULE_16: the latched-off state holds until the supply drops below the latch-reset level.
`ifndef FPS_DEFINES_VH
`define FPS_DEFINES_VH

`define CLK_HZ 10000000
`define SOFT_START_US 3500
`define SOFT_START_CYC ((`SOFT_START_US * (`CLK_HZ / 1000000)))
`define BROWNOUT_MS 32
`define BROWNOUT_CYC ((`BROWNOUT_MS * (`CLK_HZ / 1000)))
`define OVERPOWER_MS 160
`define OVERPOWER_CYC ((`OVERPOWER_MS * (`CLK_HZ / 1000)))
`define PERIOD_CYC 154
`define LOW_PERIOD_CYC 616
`define MAX_DUTY_PCT 90
`define LOW_PEAK_PCT 22
`define MAX_DUTY_STROKES 4'h8
`define OVP_CYCLES 4'h4
`define OTP_CYCLES 4'h4
`define LEVEL_MAX 8'hff

// register map
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_MASK 8'h08
`define REG_STATE 8'h0c
`define REG_LEVEL 8'h10
`define CTRL_RESET 32'h00000000
`define MASK_RESET 32'h00000000

// status bit positions
`define ST_BROWNOUT 0
`define ST_MAXDUTY 1
`define ST_OVERPOWER 2
`define ST_LOCKOUT 3
`define ST_OVP 4
`define ST_OTP 5
`define ST_START 6
`define ST_BITS 7

`endif

// ---- logic/persist_counter.v ----
// counter that fires after a condition holds for a number of qualifying steps
`timescale 1ns/100ps
module persist_counter #(
   parameter WIDTH = 24,
   parameter LIMIT = 8
) (
   input wire core_clk,
   input wire rst,
   input wire clear,
   input wire step,
   input wire cond,
   output reg fired
);
   reg [WIDTH-1:0] count;
   always @(posedge core_clk) begin
      if (rst || clear) begin
         count <= {WIDTH{1'b0}};
         fired <= 1'b0;
      end else if (step) begin
         if (!cond) begin
            // condition gone: restart the count
            count <= {WIDTH{1'b0}};
         end else if (count >= LIMIT[WIDTH-1:0] - 1'b1) begin
            fired <= 1'b1;
         end else begin
            count <= count + 1'b1;
         end
      end
   end
endmodule // persist_counter

// ---- logic/sync2.v ----
// two flip-flop synchroniser for a bundle of pin levels
`timescale 1ns/100ps
module sync2 #(
   parameter WIDTH = 1
) (
   input wire core_clk,
   input wire rst,
   input wire [WIDTH-1:0] d,
   output reg [WIDTH-1:0] q
);
   reg [WIDTH-1:0] meta;
   always @(posedge core_clk) begin
      if (rst) begin
         meta <= {WIDTH{1'b0}};
         q <= {WIDTH{1'b0}};
      end else begin
         meta <= d;
         q <= meta;
      end
   end
endmodule // sync2

// ---- logic/flyback_protection_sequencer.v ----
// start-up and protection sequencer with ahb-lite register slave
//
// Implementation choices: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/100ps
`include "fps_defines.vh"
module flyback_protection_sequencer #(
   parameter SOFT_START_CYCLES = `SOFT_START_CYC,
   parameter BROWNOUT_CYCLES = `BROWNOUT_CYC,
   parameter OVERPOWER_CYCLES = `OVERPOWER_CYC,
   parameter PERIOD = `PERIOD_CYC,
   parameter LOW_PERIOD = `LOW_PERIOD_CYC
) (
   input wire core_clk,
   input wire rst,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg [31:0] hrdata,
   output reg hreadyout,
   output reg hresp,
   input wire startup_reached,
   input wire below_lockout,
   input wire below_latch_reset,
   input wire above_ovp,
   input wire mains_above_brownin,
   input wire mains_below_brownout,
   input wire temp_above_detect,
   input wire int_overtemp,
   input wire sense_pin_ovp,
   input wire overpower_level,
   input wire low_power,
   input wire current_sense_input,
   output reg gate_drive,
   output reg [7:0] peak_limit,
   output reg supply_clamp,
   output reg power_down,
   output reg irq
);
   // *******************************************
   // states
   // *******************************************
   localparam S_WAIT = 6'b000001;
   localparam S_CHECK = 6'b000010;
   localparam S_RUN = 6'b000100;
   localparam S_DRAIN = 6'b001000;
   localparam S_RECHG = 6'b010000;
   localparam S_LATCH = 6'b100000;

   // *******************************************
   // input synchronisers
   // *******************************************
   wire [11:0] pin_q;
   sync2 #(.WIDTH(12)) u_sync (
      .core_clk(core_clk),
      .rst(rst),
      .d({startup_reached, below_lockout, below_latch_reset, above_ovp,
          mains_above_brownin, mains_below_brownout, temp_above_detect,
          int_overtemp, sense_pin_ovp, overpower_level, low_power,
          current_sense_input}),
      .q(pin_q)
   );
   wire s_startup = pin_q[11];
   wire s_lockout = pin_q[10];
   wire s_latch_rst = pin_q[9];
   wire s_ovp = pin_q[8];
   wire s_brownin = pin_q[7];
   wire s_brownout = pin_q[6];
   wire s_temp_ok = pin_q[5];
   wire s_int_ot = pin_q[4];
   wire s_is_ovp = pin_q[3];
   wire s_overpower_lvl = pin_q[2];
   wire s_low_pwr = pin_q[1];
   wire s_cs_trip = pin_q[0];

   reg [5:0] state;
   reg [5:0] next_state;
   reg [31:0] ctrl;
   reg [31:0] mask;
   reg [`ST_BITS-1:0] status;
   reg [9:0] period_cnt;
   reg [23:0] ss_cnt;
   reg [3:0] otp_cnt;
   reg stroke_maxduty;
   reg cut_off;

   wire running = (state == S_RUN);
   wire sw_enable = ctrl[0];
   wire sw_force_off = ctrl[1];

   // *******************************************
   // switching period and duty limit
   // *******************************************
   // low power stretches the period; peak stays at its floor
   wire [9:0] period_len = s_low_pwr ? LOW_PERIOD[9:0] : PERIOD[9:0];
   // product kept wide so the 90 percent cap does not wrap
   wire [19:0] on_limit = ({10'd0, period_len} * 20'd90) / 20'd100;
   wire [9:0] max_on = on_limit[9:0];
   wire period_end = (period_cnt >= period_len - 10'd1);
   wire on_window = (period_cnt < max_on);

   always @(posedge core_clk) begin
      if (rst || !running) begin
         period_cnt <= 10'd0;
      end else if (period_end) begin
         period_cnt <= 10'd0;
      end else begin
         period_cnt <= period_cnt + 10'd1;
      end
   end

   // a stroke reaching the duty cap without a current trip counts as maxduty
   always @(posedge core_clk) begin
      if (rst || !running || period_end) begin
         stroke_maxduty <= 1'b1;
      end else if (on_window && s_cs_trip) begin
         stroke_maxduty <= 1'b0;
      end
   end

   // a current trip ends the stroke until the next period starts
   always @(posedge core_clk) begin
      if (rst || !running || period_end) begin
         cut_off <= 1'b0;
      end else if (s_cs_trip) begin
         cut_off <= 1'b1;
      end
   end

   // *******************************************
   // protection detectors
   // *******************************************
   wire maxduty_fire;
   wire brownout_fire;
   wire overpower_fire;
   wire ovp_fire;
   // RULE_12: eight maxduty strokes
   persist_counter #(.WIDTH(4), .LIMIT(8)) u_maxduty (
      .core_clk(core_clk),
      .rst(rst),
      .clear(!running),
      .step(period_end),
      .cond(stroke_maxduty),
      .fired(maxduty_fire)
   );
   // RULE_13: brownout 32 ms filter
   persist_counter #(.WIDTH(24), .LIMIT(BROWNOUT_CYCLES)) u_brownout (
      .core_clk(core_clk),
      .rst(rst),
      .clear(!running),
      .step(1'b1),
      .cond(s_brownout),
      .fired(brownout_fire)
   );
   // RULE_14: overpower 160 ms timer
   persist_counter #(.WIDTH(24), .LIMIT(OVERPOWER_CYCLES)) u_overpower (
      .core_clk(core_clk),
      .rst(rst),
      .clear(!running),
      .step(1'b1),
      .cond(s_overpower_lvl),
      .fired(overpower_fire)
   );
   // RULE_15: ovp four cycles
   persist_counter #(.WIDTH(4), .LIMIT(4)) u_ovp (
      .core_clk(core_clk),
      .rst(rst),
      .clear(!running),
      .step(period_end),
      .cond(s_ovp | s_is_ovp),
      .fired(ovp_fire)
   );

   // external overtemperature counted per switching cycle
   always @(posedge core_clk) begin
      if (rst || !running) begin
         otp_cnt <= 4'h0;
      end else if (period_end) begin
         if (s_temp_ok) begin
            otp_cnt <= 4'h0;
         end else if (otp_cnt != `OTP_CYCLES) begin
            otp_cnt <= otp_cnt + 4'h1;
         end
      end
   end
   wire otp_fire = (otp_cnt == `OTP_CYCLES) || s_int_ot;

   // RULE_05: restart group
   wire restart_trip = running && (maxduty_fire || brownout_fire);
   // RULE_06: latched group
   wire latch_trip = running &&
      (overpower_fire || ovp_fire || otp_fire || s_lockout || sw_force_off);

   // *******************************************
   // sequencer
   // *******************************************
   always @* begin
      next_state = state;
      case (state)
         S_WAIT: begin
            // RULE_01: check before switching
            if (s_startup) begin
               next_state = S_CHECK;
            end
         end
         S_CHECK: begin
            // RULE_02: brownin and temperature pass
            if (s_brownin && s_temp_ok && sw_enable) begin
               next_state = S_RUN;
            end else if (!s_startup) begin
               next_state = S_WAIT;
            end
         end
         S_RUN: begin
            // RULE_09: lockout while running latches
            if (latch_trip) begin
               next_state = S_LATCH;
            end else if (restart_trip) begin
               next_state = S_DRAIN;
            end
         end
         S_DRAIN: begin
            // RULE_07: drain to lockout
            if (s_lockout) begin
               next_state = S_RECHG;
            end
         end
         S_RECHG: begin
            // RULE_07: recharge then restart
            if (s_startup) begin
               next_state = S_CHECK;
            end
         end
         S_LATCH: begin
            // RULE_16: leave only on latch reset
            if (s_latch_rst) begin
               next_state = S_WAIT;
            end
         end
         default: begin
            next_state = S_WAIT;
         end
      endcase
   end

   always @(posedge core_clk) begin
      if (rst) begin
         state <= S_WAIT;
      end else begin
         state <= next_state;
      end
   end

   // *******************************************
   // soft-start and outputs
   // *******************************************
   // RULE_03: ramp peak limit
   always @(posedge core_clk) begin
      if (rst || !running) begin
         ss_cnt <= 24'd0;
      end else if (ss_cnt < SOFT_START_CYCLES[23:0]) begin
         ss_cnt <= ss_cnt + 24'd1;
      end
   end
   wire [31:0] ramp_full = (ss_cnt * 32'd255) / SOFT_START_CYCLES;
   wire [7:0] ramp = ramp_full[7:0];
   // RULE_11: low power floor 22 percent
   wire [7:0] floor_lvl = 8'd56;
   wire [7:0] target = s_low_pwr ? floor_lvl : `LEVEL_MAX;

   always @(posedge core_clk) begin
      if (rst) begin
         gate_drive <= 1'b0;
         peak_limit <= 8'h00;
         supply_clamp <= 1'b0;
         power_down <= 1'b1;
      end else begin
         // RULE_04: stop drive on any trip
         // RULE_10: on-time capped at 90 percent
         gate_drive <= (next_state == S_RUN) && running && on_window &&
            !s_cs_trip && !cut_off && !period_end;
         peak_limit <= running ? ((ramp < target) ? ramp : target) : 8'h00;
         // RULE_08: clamp and power-down on latch
         supply_clamp <= (next_state == S_LATCH);
         // draining toward lockout is not yet the low-current mode
         power_down <= (next_state != S_RUN) && (next_state != S_CHECK) &&
            (next_state != S_DRAIN);
      end
   end

   // *******************************************
   // event status and interrupt
   // *******************************************
   wire [`ST_BITS-1:0] events;
   assign events[`ST_BROWNOUT] = running && brownout_fire;
   assign events[`ST_MAXDUTY] = running && maxduty_fire;
   assign events[`ST_OVERPOWER] = running && overpower_fire;
   assign events[`ST_LOCKOUT] = running && s_lockout;
   assign events[`ST_OVP] = running && ovp_fire;
   assign events[`ST_OTP] = running && otp_fire;
   assign events[`ST_START] = (state == S_CHECK) && (next_state == S_RUN);

   // *******************************************
   // ahb-lite slave
   // *******************************************
   reg dp_write;
   reg dp_read;
   reg [7:0] dp_addr;
   wire take = hsel && hready && htrans[1];
   wire [`ST_BITS-1:0] w1c = (dp_write && dp_addr == `REG_STATUS) ?
      hwdata[`ST_BITS-1:0] : {`ST_BITS{1'b0}};

   always @(posedge core_clk) begin
      if (rst) begin
         dp_write <= 1'b0;
         dp_read <= 1'b0;
         dp_addr <= 8'h00;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         hrdata <= 32'h00000000;
         ctrl <= `CTRL_RESET;
         mask <= `MASK_RESET;
         status <= {`ST_BITS{1'b0}};
         irq <= 1'b0;
      end else begin
         dp_write <= take && hwrite;
         dp_read <= take && !hwrite;
         dp_addr <= haddr[7:0];
         if (dp_write && dp_addr == `REG_CTRL) begin
            ctrl <= {30'h0, hwdata[1:0]};
         end
         if (dp_write && dp_addr == `REG_MASK) begin
            mask <= {25'h0, hwdata[`ST_BITS-1:0]};
         end
         // set wins over write-one clear
         status <= (status & ~w1c) | events;
         irq <= |(((status & ~w1c) | events) & mask[`ST_BITS-1:0]);
         if (take && !hwrite) begin
            case (haddr[7:0])
               `REG_CTRL: hrdata <= ctrl;
               `REG_STATUS: hrdata <= {25'h0, status};
               `REG_MASK: hrdata <= mask;
               `REG_STATE: hrdata <= {26'h0, state};
               `REG_LEVEL: hrdata <= {24'h0, peak_limit};
               default: hrdata <= 32'h00000000;
            endcase
         end
      end
   end
endmodule // flyback_protection_sequencer

// ---- testbench/fps_checker.sv ----
// assertion checker bound to the protection sequencer top
`timescale 1ns/100ps
module fps_checker (
   input wire core_clk,
   input wire rst,
   input wire below_latch_reset,
   input wire low_power,
   input wire hreadyout,
   input wire hresp,
   input wire gate_drive,
   input wire [7:0] peak_limit,
   input wire supply_clamp,
   input wire power_down
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   reg [9:0] hi_cnt;
   reg lp_ever;
   reg [5:0] bl_hist;
   // **********
   // helper logic
   // **********
   // low power stretches the period, so the on-time bound widens with it
   always @(posedge core_clk) begin
      if (rst) begin
         hi_cnt <= 10'h000;
         lp_ever <= 1'b0;
         bl_hist <= 6'h00;
      end else begin
         hi_cnt <= gate_drive ? hi_cnt + 10'h001 : 10'h000;
         lp_ever <= lp_ever | low_power;
         bl_hist <= {bl_hist[4:0], below_latch_reset};
      end
   end
   // pin sync plus state register gives three cycles of lag
   sequence supply_held;
      !below_latch_reset [*6];
   endsequence
   sequence ramp_starts;
      $past(peak_limit) == 8'h00 && peak_limit != 8'h00;
   endsequence
   // **********
   // assertions
   // **********
   reset_state_a: assert property ( // RESET
      $fell(rst) |-> {gate_drive, supply_clamp, power_down, peak_limit}
         == 11'h100) else $error("outputs wrong after reset");
   clamp_forces_off_a: assert property (
      supply_clamp |-> power_down && !gate_drive)
      else $error("clamp without power down");
   gate_needs_power_a: assert property (
      gate_drive |-> !power_down) else $error("gate during power down");
   duty_limit_a: assert property (
      hi_cnt <= (lp_ever ? 10'd554 : 10'd138))
      else $error("on time beyond ninety percent");
   soft_start_a: assert property (
      ramp_starts |-> (peak_limit != 8'hff) [*8])
      else $error("peak limit jumped to full");
   latch_holds_a: assert property (
      (supply_held ##0 supply_clamp) |=> supply_clamp)
      else $error("latch left without reset level");
   latch_exit_a: assert property (
      $fell(supply_clamp) |-> bl_hist != 6'h00)
      else $error("latch cleared without cause");
   bus_okay_a: assert property (
      hreadyout && !hresp) else $error("bus answer not ready okay");
endmodule // fps_checker
bind flyback_protection_sequencer fps_checker chk (
   .core_clk(core_clk),
   .rst(rst),
   .below_latch_reset(below_latch_reset),
   .low_power(low_power),
   .hreadyout(hreadyout),
   .hresp(hresp),
   .gate_drive(gate_drive),
   .peak_limit(peak_limit),
   .supply_clamp(supply_clamp),
   .power_down(power_down)
);

// ---- testbench/flyback_protection_sequencer_bench.sv ----
// self-checking bench for the flyback protection sequencer
`timescale 1ns/100ps
`include "fps_defines.vh"
`define CHK(n, e, g) begin \
   checked = checked + 1; \
   if ((g) !== (e)) begin \
      mismatches = mismatches + 1; \
      $display("wrong value %s expected %h seen %h", n, e, g); \
   end \
end
module flyback_protection_sequencer_bench;
   reg core_clk, rst, hwrite, startup_reached, lockout, latch_rst;
   reg mains_ok, mains_low, temp_ok, low_power, trip_en, cs_trip;
   reg [1:0] htrans;
   reg [31:0] haddr, hwdata, r;
   reg [5:0] fault;
   reg [7:0] on_cnt;
   wire [31:0] hrdata;
   wire hreadyout, hresp, gate_drive, supply_clamp, power_down, irq;
   wire [7:0] peak_limit;
   integer mismatches, checked, i, hi, per;
   flyback_protection_sequencer #(.SOFT_START_CYCLES(100),
      .BROWNOUT_CYCLES(50), .OVERPOWER_CYCLES(80)) uut (
      .core_clk(core_clk), .rst(rst), .hsel(1'b1), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .startup_reached(startup_reached),
      .below_lockout(lockout | fault[4]), .below_latch_reset(latch_rst),
      .above_ovp(fault[0]), .mains_above_brownin(mains_ok),
      .mains_below_brownout(mains_low),
      .temp_above_detect(temp_ok & ~fault[5]), .int_overtemp(fault[1]),
      .sense_pin_ovp(fault[2]), .overpower_level(fault[3]),
      .low_power(low_power), .current_sense_input(cs_trip),
      .gate_drive(gate_drive), .peak_limit(peak_limit),
      .supply_clamp(supply_clamp), .power_down(power_down), .irq(irq));
   // **********
   // clock, current trip and bus tasks
   // **********
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   // trip 20 cycles into each pulse while trip_en is set, so those strokes do not count as max duty
   always @(posedge core_clk) begin
      on_cnt <= gate_drive ? on_cnt + 8'h01 : 8'h00;
      cs_trip <= trip_en && gate_drive && on_cnt >= 8'd20;
   end
   task cyc(input integer n);
      repeat (n) @(posedge core_clk);
   endtask
   task rdy;
      begin
         @(posedge core_clk);
         while (hreadyout !== 1'b1) @(posedge core_clk);
      end
   endtask
   task ahb(input [31:0] a, input w, input [31:0] d);
      begin
         haddr <= a;
         hwrite <= w;
         htrans <= 2'h2;
         rdy;
         htrans <= 2'h0;
         hwdata <= d;
         rdy;
         r = hrdata;
      end
   endtask
   task rdchk(input [31:0] a, input [31:0] e);
      begin
         ahb(a, 1'b0, 32'h0);
         `CHK("register", e, r)
      end
   endtask
   task pulse;
      begin
         hi = 0;
         per = 0;
         while (gate_drive === 1'b1) @(posedge core_clk);
         while (gate_drive !== 1'b1) @(posedge core_clk);
         while (gate_drive === 1'b1) begin
            hi = hi + 1;
            per = per + 1;
            @(posedge core_clk);
         end
         while (gate_drive !== 1'b1) begin
            per = per + 1;
            @(posedge core_clk);
         end
      end
   endtask
   task bring_up;
      begin
         startup_reached <= 1'b0;
         lockout <= 1'b1;
         latch_rst <= 1'b1;
         cyc(10);
         lockout <= 1'b0;
         latch_rst <= 1'b0;
         startup_reached <= 1'b1;
         cyc(30);
         ahb(`REG_STATUS, 1'b1, 32'h7f);
         rdchk(`REG_STATE, 32'h4);
      end
   endtask
   task complete_run;
      begin
         if (mismatches == 0 && checked > 0)
            $display("SIMULATION PASSED");
         else
            $display("SIMULATION FAILED");
         $finish;
      end
   endtask
   initial begin
      cyc(30000);
      mismatches = mismatches + 1;
      complete_run;
   end
   // **********
   // main sequence
   // **********
   initial begin
      {rst, temp_ok, trip_en} = 3'h7;
      {hwrite, startup_reached, lockout, latch_rst} = 4'h0;
      {mains_ok, mains_low, low_power} = 3'h0;
      {htrans, haddr, hwdata, fault} = 72'h0;
      {mismatches, checked} = 64'h0;
      cyc(3);
      rst <= 1'b0;
      cyc(1);
      `CHK("reset", 12'h100, {gate_drive, supply_clamp, irq, power_down,
         peak_limit})
      rdchk(`REG_CTRL, `CTRL_RESET);
      rdchk(`REG_MASK, `MASK_RESET);
      ahb(32'h40, 1'b1, 32'hffffffff);
      rdchk(32'h40, 32'h0);
      ahb(`REG_CTRL, 1'b1, 32'h1);
      startup_reached <= 1'b1;
      for (i = 0; i < 2; i = i + 1) begin
         mains_ok <= i[0];
         temp_ok <= ~i[0];
         cyc(80);
         `CHK("gate", 1'b0, gate_drive)
         if (i == 0) rdchk(`REG_STATE, 32'h2);
      end
      temp_ok <= 1'b1;
      bring_up;
      `CHK("ramp", 1'b1, peak_limit < 8'hff)
      cyc(150);
      `CHK("full peak", 8'hff, peak_limit)
      pulse;
      `CHK("period", 154, per)
      ahb(`REG_MASK, 1'b1, 32'h2);
      trip_en <= 1'b0;
      pulse;
      `CHK("on time", 1'b1, hi <= 138 && hi > 130)
      cyc(1500);
      rdchk(`REG_STATE, 32'h8);
      `CHK("draining", 1'b0, power_down)
      rdchk(`REG_STATUS, 32'h2);
      `CHK("irq", 1'b1, irq)
      ahb(`REG_MASK, 1'b1, 32'h0);
      cyc(2);
      `CHK("irq", 1'b0, irq)
      ahb(`REG_MASK, 1'b1, 32'h2);
      ahb(`REG_STATUS, 1'b1, 32'h2);
      cyc(2);
      `CHK("irq", 1'b0, irq)
      trip_en <= 1'b1;
      startup_reached <= 1'b0;
      lockout <= 1'b1;
      cyc(10);
      rdchk(`REG_STATE, 32'h10);
      `CHK("powered down", 2'h2, {power_down, supply_clamp})
      lockout <= 1'b0;
      cyc(20);
      `CHK("gate", 1'b0, gate_drive)
      startup_reached <= 1'b1;
      cyc(30);
      rdchk(`REG_STATE, 32'h4);
      ahb(`REG_STATUS, 1'b1, 32'h7f);
      mains_low <= 1'b1;
      cyc(40);
      mains_low <= 1'b0;
      cyc(10);
      rdchk(`REG_STATE, 32'h4);
      mains_low <= 1'b1;
      cyc(70);
      mains_low <= 1'b0;
      rdchk(`REG_STATE, 32'h8);
      rdchk(`REG_STATUS, 32'h1);
      bring_up;
      low_power <= 1'b1;
      cyc(1300);
      pulse;
      `CHK("low period", 616, per)
      `CHK("low peak", 8'h38, peak_limit)
      low_power <= 1'b0;
      fault <= 6'h01;
      cyc(300);
      fault <= 6'h00;
      cyc(10);
      rdchk(`REG_STATE, 32'h4);
      fault <= 6'h08;
      cyc(40);
      fault <= 6'h00;
      cyc(10);
      rdchk(`REG_STATE, 32'h4);
      // each latching cause in turn: ovp, otp, sense ovp, overpower,
      // lockout, ntc
      for (i = 0; i < 6; i = i + 1) begin
         bring_up;
         fault <= 6'h01 << i;
         cyc(1000);
         rdchk(`REG_STATE, 32'h20);
         `CHK("off", 3'h6, {supply_clamp, power_down, gate_drive})
         ahb(`REG_STATUS, 1'b0, 32'h0);
         `CHK("cause", 1'b1, r[(24'h532454 >> (4 * i)) & 24'hf])
         fault <= 6'h00;
         cyc(20);
         `CHK("held", 1'b1, supply_clamp)
         startup_reached <= 1'b0;
         latch_rst <= 1'b1;
         cyc(10);
         rdchk(`REG_STATE, 32'h1);
      end
      complete_run;
   end
endmodule // flyback_protection_sequencer_bench
